/* src/i2cmte_pkg.sv */
package i2cmte_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_BEGIN_RX      = 12'h000;
  localparam logic [11:0] OFF_BEGIN_TX      = 12'h008;
  localparam logic [11:0] OFF_HALT          = 12'h014;
  localparam logic [11:0] OFF_PAUSE         = 12'h01c;
  localparam logic [11:0] OFF_CONTINUE      = 12'h020;
  localparam logic [11:0] OFF_SUB_RX        = 12'h080;
  localparam logic [11:0] OFF_SUB_TX        = 12'h088;
  localparam logic [11:0] OFF_SUB_HALT      = 12'h094;
  localparam logic [11:0] OFF_SUB_PAUSE     = 12'h09c;
  localparam logic [11:0] OFF_SUB_CONTINUE  = 12'h0a0;
  localparam logic [11:0] OFF_EV_HALTED     = 12'h104;
  localparam logic [11:0] OFF_EV_FAULT      = 12'h124;
  localparam logic [11:0] OFF_EV_PAUSED     = 12'h148;
  localparam logic [11:0] OFF_EV_RX_BEGUN   = 12'h14c;
  localparam logic [11:0] OFF_EV_TX_BEGUN   = 12'h150;
  localparam logic [11:0] OFF_EV_FINAL_RX   = 12'h15c;
  localparam logic [11:0] OFF_EV_FINAL_TX   = 12'h160;
  localparam logic [11:0] OFF_PUB_HALTED    = 12'h184;
  localparam logic [11:0] OFF_PUB_FAULT     = 12'h1a4;
  localparam logic [11:0] OFF_PUB_PAUSED    = 12'h1c8;
  localparam logic [11:0] OFF_PUB_RX_BEGUN  = 12'h1cc;
  localparam logic [11:0] OFF_PUB_TX_BEGUN  = 12'h1d0;
  localparam logic [11:0] OFF_PUB_FINAL_RX  = 12'h1dc;
  localparam logic [11:0] OFF_IRQ_STATUS    = 12'h600;
  localparam logic [11:0] OFF_IRQ_MASK      = 12'h604;
  localparam logic [11:0] OFF_RX_LIMIT      = 12'h608;
  localparam logic [11:0] OFF_TX_LIMIT      = 12'h548;
  localparam logic [11:0] OFF_TX_COUNT      = 12'h54c;
  localparam logic [11:0] OFF_TX_LIST       = 12'h550;
  localparam logic [11:0] OFF_TARGET_ADDR   = 12'h588;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int          CHAN_W            = 8;
  localparam int          EN_BIT            = 31;
  localparam int          NUM_EV            = 7;
  localparam int          ADDR_W            = 7;
  localparam int          CNT_W             = 16;
  localparam int          LIST_W            = 2;
  localparam logic [31:0] RESET_WORD        = 32'h0000_0000;

  // event indices in status/mask/publish arrays
  localparam int          EV_HALTED         = 0;
  localparam int          EV_FAULT          = 1;
  localparam int          EV_PAUSED         = 2;
  localparam int          EV_RX_BEGUN       = 3;
  localparam int          EV_TX_BEGUN       = 4;
  localparam int          EV_FINAL_RX       = 5;
  localparam int          EV_FINAL_TX       = 6;

  typedef enum logic [2:0] {
    I2CMTE_CMD_RX,
    I2CMTE_CMD_TX,
    I2CMTE_CMD_HALT,
    I2CMTE_CMD_PAUSE,
    I2CMTE_CMD_CONTINUE
  } i2cmte_cmd_t;

  localparam int          NUM_TASK          = 5;

endpackage

/* src/i2cmte_chan_sel.sv */
`timescale 1ns/1ns
module i2cmte_chan_sel
  import i2cmte_pkg::*;
#(
  parameter int NCH = 256
) (
  // configuration
  input  wire logic [31:0]    config_word,
  // fabric
  input  wire logic [NCH-1:0] channels,
  // result
  output logic                hit
);
  // ----------------------------------------------------------------
  // subscription select
  // ----------------------------------------------------------------
  // a disabled subscription ignores every channel
  assign hit = config_word[EN_BIT] & channels[config_word[CHAN_W-1:0]];
endmodule

/* src/i2cmte_engine.sv */
`timescale 1ns/1ns
module i2cmte_engine
  import i2cmte_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // tasks
  input  wire logic             do_rx,
  input  wire logic             do_tx,
  input  wire logic             do_halt,
  input  wire logic             do_pause,
  input  wire logic             do_continue,
  // settings
  input  wire logic [CNT_W-1:0] tx_limit,
  input  wire logic [CNT_W-1:0] rx_limit,
  input  wire logic [ADDR_W-1:0] addr,
  // byte-level bus side
  input  wire logic             byte_done,
  input  wire logic             nack,
  output logic                  bus_busy,
  output logic                  bus_read,
  output logic [ADDR_W-1:0]     bus_addr,
  // events
  output logic [NUM_EV-1:0]     ev,
  output logic [CNT_W-1:0]      moved
);
  typedef enum logic [1:0] {I2CMTE_IDLE, I2CMTE_RUN, I2CMTE_PAUSED} i2cmte_st_t;
  typedef struct packed {
    i2cmte_st_t       st;
    logic             rd;
    logic [ADDR_W-1:0] a;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] lim;
    logic [CNT_W-1:0] moved;
    logic [NUM_EV-1:0] ev;
  } i2cmte_eng_t;
  i2cmte_eng_t s, next_s;

  always_comb begin
    next_s = s;
    next_s.ev = '0;
    case (s.st)
      I2CMTE_IDLE: begin
        if (do_rx || do_tx) begin
          next_s.st = I2CMTE_RUN;
          next_s.rd = do_rx;
          next_s.a = addr;
          next_s.cnt = '0;
          next_s.lim = do_rx ? rx_limit : tx_limit;
          next_s.ev[do_rx ? EV_RX_BEGUN : EV_TX_BEGUN] = 1'b1;
          if ((do_rx ? rx_limit : tx_limit) == CNT_W'(1))
            next_s.ev[do_rx ? EV_FINAL_RX : EV_FINAL_TX] = 1'b1;
        end
      end
      I2CMTE_RUN: begin
        if (do_halt || nack || (byte_done && (s.cnt + CNT_W'(1) >= s.lim)) || s.lim == '0) begin
          next_s.st = I2CMTE_IDLE;
          next_s.moved = (byte_done && s.lim != '0) ? s.cnt + CNT_W'(1) : s.cnt;
          next_s.ev[EV_HALTED] = 1'b1;
          next_s.ev[EV_FAULT] = nack;
        end else if (do_pause) begin
          next_s.st = I2CMTE_PAUSED;
          next_s.ev[EV_PAUSED] = 1'b1;
        end else if (byte_done) begin
          next_s.cnt = s.cnt + CNT_W'(1);
          if (s.cnt + CNT_W'(2) == s.lim)
            next_s.ev[s.rd ? EV_FINAL_RX : EV_FINAL_TX] = 1'b1;
        end
      end
      I2CMTE_PAUSED: begin
        // stop here is illegal; resume continues at the saved byte count
        if (do_continue)
          next_s.st = I2CMTE_RUN;
      end
      default: next_s.st = I2CMTE_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign bus_busy = (s.st == I2CMTE_RUN);
  assign bus_read = s.rd;
  assign bus_addr = s.a;
  assign ev       = s.ev;
  assign moved    = s.moved;
endmodule

/* src/i2cmte_regs.sv */
`timescale 1ns/1ns
// Contract
// - halt trigger ends transaction, not while paused
// - paused flag set once traffic halts
// - final rx flag at last byte start
// - final tx flag at last byte start
// - subscription: channel index plus enable
// - publication: channel index plus enable
// - never send more than tx limit
// - tx count holds bytes last moved
// - target address used as slave address
module i2cmte_regs
  import i2cmte_pkg::*;
#(
  parameter int NCH = 256
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // avalon-mm slave
  input  wire logic [11:0]       avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  output logic [1:0]             avs_response,
  // event channel fabric
  input  wire logic [NCH-1:0]    chan_in,
  output logic [NCH-1:0]         chan_out,
  // byte-level bus side
  input  wire logic              byte_done,
  input  wire logic              nack,
  output logic                   bus_busy,
  output logic                   bus_read,
  output logic [ADDR_W-1:0]      bus_addr,
  // interrupt
  output logic                   irq
);
  import i2cmte_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NUM_TASK-1:0][31:0] sub;
    logic [NUM_EV-1:0][31:0]   pub;
    logic [NUM_EV-1:0]         stat;
    logic [NUM_EV-1:0]         mask;
    logic [CNT_W-1:0]          tx_limit;
    logic [CNT_W-1:0]          rx_limit;
    logic [LIST_W-1:0]         list;
    logic [ADDR_W-1:0]         addr;
    logic [NUM_TASK-1:0]       sw_task;
    logic [NUM_EV-1:0]         ev_d;
    logic [NCH-1:0]            chan_out;
    logic                      ack;
    logic [31:0]               rdata;
    logic [1:0]                resp;
    logic                      held;
  } i2cmte_regs_t;
  i2cmte_regs_t s, next_s;

  logic [NUM_TASK-1:0] hw_task;
  logic [NUM_TASK-1:0] task_go;
  logic [NUM_EV-1:0]   ev;
  logic [CNT_W-1:0]    moved;
  logic                req;
  logic [NUM_TASK-1:0] hit_w;

  // 32-bit write with byte enables
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[8*i +: 8] = wd[8*i +: 8];
    return r;
  endfunction

  // only enable and channel fields are kept
  function automatic logic [31:0] cfg_mask(input logic [31:0] w);
    return w & ({32'h1 << EN_BIT} | 32'(1 << CHAN_W) - 32'h1);
  endfunction

  // ----------------------------------------------------------------
  // task sources
  // ----------------------------------------------------------------
  for (genvar t = 0; t < NUM_TASK; t++) begin : g_sub
    i2cmte_chan_sel #(.NCH(NCH)) u_sel (
      .config_word (s.sub[t]),
      .channels    (chan_in),
      .hit         (hit_w[t])
    );
  end
  assign hw_task = hit_w;
  assign task_go = hw_task | s.sw_task;

  i2cmte_engine u_eng (
    .clk         (clk),
    .resetn      (resetn),
    .do_rx       (task_go[I2CMTE_CMD_RX]),
    .do_tx       (task_go[I2CMTE_CMD_TX]),
    .do_halt     (task_go[I2CMTE_CMD_HALT]),
    .do_pause    (task_go[I2CMTE_CMD_PAUSE]),
    .do_continue (task_go[I2CMTE_CMD_CONTINUE]),
    .tx_limit    (s.tx_limit),
    .rx_limit    (s.rx_limit),
    .addr        (s.addr),
    .byte_done   (byte_done),
    .nack        (nack),
    .bus_busy    (bus_busy),
    .bus_read    (bus_read),
    .bus_addr    (bus_addr),
    .ev          (ev),
    .moved       (moved)
  );

  assign req = (avs_read || avs_write) && !s.ack;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.sw_task = '0;
    next_s.ack = req;
    next_s.resp = 2'h0;
    next_s.ev_d = ev;
    next_s.chan_out = '0;
    // mirrors the engine's paused state for the resume check
    next_s.held = ev[EV_PAUSED] | (s.held & !bus_busy);
    // publish one-cycle pulses on enabled channels
    for (int e = 0; e < NUM_EV; e++)
      if (ev[e] && s.pub[e][EN_BIT])
        next_s.chan_out[s.pub[e][CHAN_W-1:0]] = 1'b1;
    // a write commits only at the edge after its wait state, while waitrequest is low
    if (avs_write && s.ack) begin
      case (avs_address)
        OFF_BEGIN_RX:     next_s.sw_task[I2CMTE_CMD_RX] = avs_writedata[0];
        OFF_BEGIN_TX:     next_s.sw_task[I2CMTE_CMD_TX] = avs_writedata[0];
        OFF_HALT:         next_s.sw_task[I2CMTE_CMD_HALT] = avs_writedata[0];
        OFF_PAUSE:        next_s.sw_task[I2CMTE_CMD_PAUSE] = avs_writedata[0];
        OFF_CONTINUE:     next_s.sw_task[I2CMTE_CMD_CONTINUE] = avs_writedata[0];
        OFF_SUB_RX:       next_s.sub[I2CMTE_CMD_RX] = cfg_mask(merge(s.sub[0], avs_writedata, avs_byteenable));
        OFF_SUB_TX:       next_s.sub[I2CMTE_CMD_TX] = cfg_mask(merge(s.sub[1], avs_writedata, avs_byteenable));
        OFF_SUB_HALT:     next_s.sub[I2CMTE_CMD_HALT] = cfg_mask(merge(s.sub[2], avs_writedata, avs_byteenable));
        OFF_SUB_PAUSE:    next_s.sub[I2CMTE_CMD_PAUSE] = cfg_mask(merge(s.sub[3], avs_writedata, avs_byteenable));
        OFF_SUB_CONTINUE: next_s.sub[I2CMTE_CMD_CONTINUE] = cfg_mask(merge(s.sub[4], avs_writedata, avs_byteenable));
        OFF_EV_HALTED:    next_s.stat[EV_HALTED] = avs_writedata[0];
        OFF_EV_FAULT:     next_s.stat[EV_FAULT] = avs_writedata[0];
        OFF_EV_PAUSED:    next_s.stat[EV_PAUSED] = avs_writedata[0];
        OFF_EV_RX_BEGUN:  next_s.stat[EV_RX_BEGUN] = avs_writedata[0];
        OFF_EV_TX_BEGUN:  next_s.stat[EV_TX_BEGUN] = avs_writedata[0];
        OFF_EV_FINAL_RX:  next_s.stat[EV_FINAL_RX] = avs_writedata[0];
        OFF_EV_FINAL_TX:  next_s.stat[EV_FINAL_TX] = avs_writedata[0];
        OFF_PUB_HALTED:   next_s.pub[EV_HALTED] = cfg_mask(merge(s.pub[0], avs_writedata, avs_byteenable));
        OFF_PUB_FAULT:    next_s.pub[EV_FAULT] = cfg_mask(merge(s.pub[1], avs_writedata, avs_byteenable));
        OFF_PUB_PAUSED:   next_s.pub[EV_PAUSED] = cfg_mask(merge(s.pub[2], avs_writedata, avs_byteenable));
        OFF_PUB_RX_BEGUN: next_s.pub[EV_RX_BEGUN] = cfg_mask(merge(s.pub[3], avs_writedata, avs_byteenable));
        OFF_PUB_TX_BEGUN: next_s.pub[EV_TX_BEGUN] = cfg_mask(merge(s.pub[4], avs_writedata, avs_byteenable));
        OFF_PUB_FINAL_RX: next_s.pub[EV_FINAL_RX] = cfg_mask(merge(s.pub[5], avs_writedata, avs_byteenable));
        OFF_IRQ_STATUS:   next_s.stat = s.stat & ~avs_writedata[NUM_EV-1:0];
        OFF_IRQ_MASK:     next_s.mask = avs_writedata[NUM_EV-1:0];
        OFF_TX_LIMIT:     next_s.tx_limit = avs_writedata[CNT_W-1:0];
        OFF_RX_LIMIT:     next_s.rx_limit = avs_writedata[CNT_W-1:0];
        OFF_TX_LIST:      next_s.list = avs_writedata[LIST_W-1:0];
        OFF_TARGET_ADDR:  next_s.addr = avs_writedata[ADDR_W-1:0];
        OFF_TX_COUNT:     next_s.resp = 2'h0;
        default:          next_s.resp = 2'h3;
      endcase
    end
    if (req && avs_read) begin
      next_s.rdata = RESET_WORD;
      case (avs_address)
        OFF_SUB_RX:       next_s.rdata = s.sub[I2CMTE_CMD_RX];
        OFF_SUB_TX:       next_s.rdata = s.sub[I2CMTE_CMD_TX];
        OFF_SUB_HALT:     next_s.rdata = s.sub[I2CMTE_CMD_HALT];
        OFF_SUB_PAUSE:    next_s.rdata = s.sub[I2CMTE_CMD_PAUSE];
        OFF_SUB_CONTINUE: next_s.rdata = s.sub[I2CMTE_CMD_CONTINUE];
        OFF_EV_HALTED:    next_s.rdata = 32'(s.stat[EV_HALTED]);
        OFF_EV_FAULT:     next_s.rdata = 32'(s.stat[EV_FAULT]);
        OFF_EV_PAUSED:    next_s.rdata = 32'(s.stat[EV_PAUSED]);
        OFF_EV_RX_BEGUN:  next_s.rdata = 32'(s.stat[EV_RX_BEGUN]);
        OFF_EV_TX_BEGUN:  next_s.rdata = 32'(s.stat[EV_TX_BEGUN]);
        OFF_EV_FINAL_RX:  next_s.rdata = 32'(s.stat[EV_FINAL_RX]);
        OFF_EV_FINAL_TX:  next_s.rdata = 32'(s.stat[EV_FINAL_TX]);
        OFF_PUB_HALTED:   next_s.rdata = s.pub[EV_HALTED];
        OFF_PUB_FAULT:    next_s.rdata = s.pub[EV_FAULT];
        OFF_PUB_PAUSED:   next_s.rdata = s.pub[EV_PAUSED];
        OFF_PUB_RX_BEGUN: next_s.rdata = s.pub[EV_RX_BEGUN];
        OFF_PUB_TX_BEGUN: next_s.rdata = s.pub[EV_TX_BEGUN];
        OFF_PUB_FINAL_RX: next_s.rdata = s.pub[EV_FINAL_RX];
        OFF_IRQ_STATUS:   next_s.rdata = 32'(s.stat);
        OFF_IRQ_MASK:     next_s.rdata = 32'(s.mask);
        OFF_TX_LIMIT:     next_s.rdata = 32'(s.tx_limit);
        OFF_RX_LIMIT:     next_s.rdata = 32'(s.rx_limit);
        OFF_TX_COUNT:     next_s.rdata = 32'(moved);
        OFF_TX_LIST:      next_s.rdata = 32'(s.list);
        OFF_TARGET_ADDR:  next_s.rdata = 32'(s.addr);
        OFF_BEGIN_RX, OFF_BEGIN_TX, OFF_HALT, OFF_PAUSE, OFF_CONTINUE: next_s.rdata = RESET_WORD;
        default:          next_s.resp = 2'h3;
      endcase
    end
    // hardware set wins over a software clear in the same cycle
    next_s.stat = next_s.stat | ev;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      s <= '0;
    else
      s <= next_s;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign avs_waitrequest = (avs_read || avs_write) && !s.ack;
  assign avs_readdata    = s.rdata;
  assign avs_response    = s.resp;
  assign chan_out        = s.chan_out;
  assign irq             = |(s.stat & s.mask);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_pause_flag;
    @(posedge clk) disable iff (!resetn)
      (bus_busy && task_go[I2CMTE_CMD_PAUSE] && !task_go[I2CMTE_CMD_HALT] && !nack && !byte_done)
      |=> !bus_busy ##1 s.stat[EV_PAUSED];
  endproperty
  a_pause_flag: assert property (p_pause_flag) else $error("pause did not set paused flag");

  property p_halt_ends;
    @(posedge clk) disable iff (!resetn)
      (bus_busy && task_go[I2CMTE_CMD_HALT]) |=> !bus_busy ##1 s.stat[EV_HALTED];
  endproperty
  a_halt_ends: assert property (p_halt_ends) else $error("halt did not end transaction");

  property p_final_rx;
    @(posedge clk) disable iff (!resetn) ev[EV_FINAL_RX] |-> bus_read || !bus_busy;
  endproperty
  a_final_rx: assert property (p_final_rx) else $error("final rx flag during write");

  property p_final_tx;
    @(posedge clk) disable iff (!resetn) ev[EV_FINAL_TX] |=> s.stat[EV_FINAL_TX];
  endproperty
  a_final_tx: assert property (p_final_tx) else $error("final tx flag not latched");

  property p_sub_dis;
    @(posedge clk) disable iff (!resetn) !s.sub[I2CMTE_CMD_TX][EN_BIT] |-> !hw_task[I2CMTE_CMD_TX];
  endproperty
  a_sub_dis: assert property (p_sub_dis) else $error("disabled subscription fired");

  property p_pub;
    @(posedge clk) disable iff (!resetn)
      (ev[EV_HALTED] && s.pub[EV_HALTED][EN_BIT]) |=> chan_out[$past(s.pub[EV_HALTED][CHAN_W-1:0])];
  endproperty
  a_pub: assert property (p_pub) else $error("halted event not published");

  property p_limit;
    @(posedge clk) disable iff (!resetn) (ev[EV_HALTED] && !bus_read) |=> moved <= $past(s.tx_limit, 2);
  endproperty
  a_limit: assert property (p_limit) else $error("more bytes than tx limit");

  property p_addr;
    @(posedge clk) disable iff (!resetn) $rose(bus_busy) |-> bus_addr == $past(s.addr);
  endproperty
  a_addr: assert property (p_addr) else $error("wrong slave address");

  property p_resume;
    @(posedge clk) disable iff (!resetn)
      ((ev[EV_PAUSED] || s.held) && !bus_busy && task_go[I2CMTE_CMD_CONTINUE]) |=> bus_busy;
  endproperty
  a_resume: assert property (p_resume) else $error("continue did not resume");

  property p_wait_one;
    @(posedge clk) disable iff (!resetn)
      avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("second wait state");

  property p_rdata_hold;
    @(posedge clk) disable iff (!resetn)
      !(avs_read && avs_waitrequest) |=> $stable(avs_readdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without read");

  property p_sub_rx;
    @(posedge clk) disable iff (!resetn)
      !s.sub[I2CMTE_CMD_RX][EN_BIT] |-> !hw_task[I2CMTE_CMD_RX];
  endproperty
  a_sub_rx: assert property (p_sub_rx) else $error("disabled rx subscription fired");

  property p_pub_src;
    @(posedge clk) disable iff (!resetn)
      (|chan_out) |-> $past(|ev);
  endproperty
  a_pub_src: assert property (p_pub_src) else $error("publish pulse without event");

  property p_final_tx_dir;
    @(posedge clk) disable iff (!resetn)
      ev[EV_FINAL_TX] |-> !bus_read || !bus_busy;
  endproperty
  a_final_tx_dir: assert property (p_final_tx_dir) else $error("final tx flag during read");

  property p_moved_hold;
    @(posedge clk) disable iff (!resetn)
      !ev[EV_HALTED] |-> $stable(moved);
  endproperty
  a_moved_hold: assert property (p_moved_hold) else $error("count changed mid transfer");

  property p_nack_ends;
    @(posedge clk) disable iff (!resetn)
      (bus_busy && nack) |=> !bus_busy;
  endproperty
  a_nack_ends: assert property (p_nack_ends) else $error("bus error did not end transfer");

  property p_irq_clear;
    @(posedge clk) disable iff (!resetn)
      (avs_write && !avs_waitrequest && avs_address == OFF_IRQ_STATUS && avs_writedata[EV_FAULT] && !ev[EV_FAULT])
      |=> !s.stat[EV_FAULT];
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("status bit not cleared");

  c_tx: cover property (@(posedge clk) disable iff (!resetn) ev[EV_TX_BEGUN] ##[1:50] ev[EV_HALTED]);
  c_pause: cover property (@(posedge clk) disable iff (!resetn) ev[EV_PAUSED] ##[1:50] bus_busy);
  c_irq: cover property (@(posedge clk) disable iff (!resetn) $rose(irq));
  c_rx: cover property (@(posedge clk) disable iff (!resetn) ev[EV_RX_BEGUN] ##[1:50] ev[EV_HALTED]);
  c_resume: cover property (@(posedge clk) disable iff (!resetn) s.held && task_go[I2CMTE_CMD_CONTINUE]);
endmodule

/* dv/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  import i2cmte_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic              clk;
  logic              resetn;
  logic [11:0]       avs_address;
  logic              avs_read;
  logic              avs_write;
  logic [31:0]       avs_writedata;
  logic [3:0]        avs_byteenable;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic [1:0]        avs_response;
  logic [255:0]      chan_in;
  logic [255:0]      chan_out;
  logic              byte_done;
  logic              nack;
  logic              bus_busy;
  logic              bus_read;
  logic [ADDR_W-1:0] bus_addr;
  logic              irq;
  int                err_total;
  int                num_checks;
  int                pub_hits;
  int                stray;
  logic [31:0]       rd;
  logic [1:0]        rsp;
  logic [11:0]       flag_off [7] = '{OFF_EV_HALTED, OFF_EV_FAULT, OFF_EV_PAUSED, OFF_EV_RX_BEGUN,
                                      OFF_EV_TX_BEGUN, OFF_EV_FINAL_RX, OFF_EV_FINAL_TX};

  i2cmte_regs #(.NCH(256)) u_i2cmte_regs (
    .clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .chan_in(chan_in), .chan_out(chan_out),
    .byte_done(byte_done), .nack(nack), .bus_busy(bus_busy), .bus_read(bus_read), .bus_addr(bus_addr),
    .irq(irq));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // one channel carries the only enabled publication; anything else is stray
  always @(posedge clk) begin
    if (chan_out[200] === 1'b1) pub_hits++;
    if ((chan_out & ~(256'h1 << 200)) !== 256'h0) stray++;
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
    @(posedge clk);
    avs_address   <= a;
    avs_byteenable <= be;
    avs_writedata <= d;
    avs_write     <= 1'b1;
    @(posedge clk iff avs_waitrequest === 1'b0);
    avs_write     <= 1'b0;
  endtask

  task automatic rdw(input logic [11:0] a);
    @(posedge clk);
    avs_address <= a;
    avs_read    <= 1'b1;
    @(posedge clk iff avs_waitrequest === 1'b0);
    rd  = avs_readdata;
    rsp = avs_response;
    avs_read    <= 1'b0;
  endtask

  task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    rdw(a);
    chk(what, exp, rd);
  endtask

  // trigger to status takes two cycles; four leaves margin
  task automatic settle();
    repeat (4) @(posedge clk);
  endtask

  task automatic bytes(input int n);
    repeat (n) begin
      @(posedge clk) byte_done <= 1'b1;
      @(posedge clk) byte_done <= 1'b0;
      @(posedge clk);
    end
  endtask

  task automatic clr_flags();
    foreach (flag_off[i]) wr(flag_off[i], 32'h0);
    wr(OFF_IRQ_STATUS, 32'h7f);
  endtask

  task automatic chan_pulse(input int ch);
    @(posedge clk) chan_in[ch] <= 1'b1;
    @(posedge clk) chan_in <= '0;
    settle();
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rchk("sub_tx", OFF_SUB_TX, RESET_WORD);
    rchk("sub_continue", OFF_SUB_CONTINUE, RESET_WORD);
    rchk("pub_rx_begun", OFF_PUB_RX_BEGUN, RESET_WORD);
    rchk("halt_reg", OFF_HALT, RESET_WORD);
    rchk("unmapped", 12'h7fc, 32'h0);
    chk("unmapped_resp", 32'h3, {30'h0, rsp});
    wr(OFF_TX_LIST, 32'h3);
    rchk("tx_list", OFF_TX_LIST, 32'h3);
    wr(OFF_SUB_HALT, 32'h8000_0033, 4'h1);
    rchk("sub_be", OFF_SUB_HALT, 32'h33);
    wr(OFF_TX_COUNT, 32'h0000_00ff);
    rchk("tx_count_ro", OFF_TX_COUNT, 32'h0);
  endtask

  task automatic t_tx();
    clr_flags();
    wr(OFF_TARGET_ADDR, 32'h2a);
    wr(OFF_TX_LIMIT, 32'h2);
    wr(OFF_BEGIN_TX, 32'h1);
    settle();
    chk("busy", 1, bus_busy);
    chk("bus_addr", 32'h2a, bus_addr);
    chk("bus_read", 0, bus_read);
    rchk("final_tx_early", OFF_EV_FINAL_TX, 32'h0);
    bytes(1);
    settle();
    rchk("final_tx", OFF_EV_FINAL_TX, 32'h1);
    bytes(1);
    settle();
    chk("busy_end", 0, bus_busy);
    bytes(1);
    rchk("tx_count", OFF_TX_COUNT, 32'h2);
    rchk("halted", OFF_EV_HALTED, 32'h1);
  endtask

  task automatic t_rx();
    clr_flags();
    wr(OFF_TARGET_ADDR, 32'h15);
    wr(OFF_RX_LIMIT, 32'h1);
    wr(OFF_BEGIN_RX, 32'h1);
    settle();
    chk("rx_read", 1, bus_read);
    chk("rx_addr", 32'h15, bus_addr);
    rchk("final_rx", OFF_EV_FINAL_RX, 32'h1);
    bytes(1);
    settle();
    chk("rx_busy_end", 0, bus_busy);
  endtask

  task automatic t_pause();
    clr_flags();
    wr(OFF_TX_LIMIT, 32'h3);
    wr(OFF_BEGIN_TX, 32'h1);
    bytes(1);
    wr(OFF_PAUSE, 32'h1);
    settle();
    rchk("paused", OFF_EV_PAUSED, 32'h1);
    rchk("paused_not_halted", OFF_EV_HALTED, 32'h0);
    wr(OFF_CONTINUE, 32'h1);
    settle();
    chk("resumed_busy", 1, bus_busy);
    bytes(2);
    settle();
    chk("resumed_end", 0, bus_busy);
    rchk("resumed_count", OFF_TX_COUNT, 32'h3);
    clr_flags();
    wr(OFF_TX_LIMIT, 32'h5);
    wr(OFF_BEGIN_TX, 32'h1);
    bytes(1);
    wr(OFF_HALT, 32'h1);
    settle();
    chk("halt_busy", 0, bus_busy);
    rchk("halt_flag", OFF_EV_HALTED, 32'h1);
    rchk("halt_count", OFF_TX_COUNT, 32'h1);
  endtask

  task automatic t_sub();
    wr(OFF_SUB_TX, 32'h8000_0005);
    rchk("sub_rb", OFF_SUB_TX, 32'h8000_0005);
    wr(OFF_TX_LIMIT, 32'h1);
    chan_pulse(6);
    chk("other_chan", 0, bus_busy);
    chan_pulse(5);
    chk("sub_start", 1, bus_busy);
    bytes(1);
    settle();
    wr(OFF_SUB_TX, 32'h0000_0005);
    chan_pulse(5);
    chk("sub_off", 0, bus_busy);
  endtask

  task automatic t_pub();
    wr(OFF_PUB_HALTED, 32'h8000_00c8);
    pub_hits = 0;
    stray    = 0;
    wr(OFF_BEGIN_TX, 32'h1);
    bytes(1);
    settle();
    chk("pub_hits", 1, pub_hits);
    wr(OFF_PUB_HALTED, 32'h0000_00c8);
    wr(OFF_BEGIN_TX, 32'h1);
    bytes(1);
    settle();
    chk("pub_off", 1, pub_hits);
    chk("pub_stray", 0, stray);
  endtask

  task automatic t_irq();
    clr_flags();
    wr(OFF_IRQ_MASK, 32'h1 << EV_FAULT);
    settle();
    chk("irq_idle", 0, irq);
    wr(OFF_TX_LIMIT, 32'h4);
    wr(OFF_BEGIN_TX, 32'h1);
    settle();
    chk("irq_masked", 0, irq);
    @(posedge clk) nack <= 1'b1;
    @(posedge clk) nack <= 1'b0;
    settle();
    chk("irq_fault", 1, irq);
    rchk("fault_flag", OFF_EV_FAULT, 32'h1);
    wr(OFF_IRQ_STATUS, 32'h1 << EV_FAULT);
    settle();
    chk("irq_cleared", 0, irq);
  endtask
  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    finish_test();
  end

  initial begin
    resetn = 1'b0;
    avs_address = 12'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    chan_in = '0;
    byte_done = 1'b0;
    nack = 1'b0;
    err_total = 0;
    num_checks = 0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_tx();
    t_rx();
    t_pause();
    t_sub();
    t_pub();
    t_irq();
    finish_test();
  end
endmodule
